/* dv/csio_partner.sv */
`default_nettype none
module csio_partner (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // trigger levels asked by the bench
   input  wire logic [1:0] lvl_i,
   // lines towards the camera
   output var  logic [1:0] sync_o = 2'h0,
   output var  logic       txd_o  = 1'h1,
   output var  logic       rxd_o  = 1'h1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt = 8'h00;
   ////////////////////////////////////////////////////////////////////////////
   // trigger source, serial lines idle high in reset
   always @(posedge clk_i) begin
      sync_o <= lvl_i;
      cnt <= rst_i ? 8'h00 : cnt + 8'h01;
      txd_o <= rst_i | cnt[3];
      rxd_o <= rst_i | (cnt[5] ^ cnt[3]);
   end
endmodule // csio_partner
`default_nettype wire

/* dv/csio_top_asserts.sv */
`default_nettype none
module csio_top_asserts (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       rst_i,
   // bus
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic [7:0] adr_i,
   input wire logic       ack_o,
   input wire logic       err_o,
   // pins
   input wire logic [1:0] sync_out_o,
   input wire logic       host_txd_i,
   input wire logic       per_rxd_i,
   input wire logic       per_txd_o,
   input wire logic       host_rxd_o,
   // status
   input wire logic       link_up_i,
   input wire logic       net_act_i,
   input wire logic       boot_done_i,
   input wire logic       fault_i,
   input wire logic       led1_o,
   input wire logic       led2_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_req;
      cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   sequence s_tx_quiet;
      $stable(host_txd_i) [*5];
   endsequence
   sequence s_rx_quiet;
      $stable(per_rxd_i) [*5];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_bus_answer: assert property (s_req |=> ack_o || err_o)
      else $error("bus request not answered");
   a_ack_single: assert property (ack_o || err_o |=> !ack_o && !err_o)
      else $error("answer longer than one cycle");
   a_no_spurious: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
      else $error("answer without request");
   a_err_unmapped: assert property (cyc_i && stb_i && !ack_o && !err_o && adr_i > 8'h28
      |=> err_o && !ack_o)
      else $error("unmapped address not refused");
   a_reset_state: assert property ($fell(rst_i) |-> sync_out_o == 2'b00 && per_txd_o
      && host_rxd_o && !led1_o && !led2_o)
      else $error("outputs not at reset level");
   a_host_to_per: assert property (s_tx_quiet |-> per_txd_o == host_txd_i)
      else $error("host serial not forwarded");
   a_per_to_host: assert property (s_rx_quiet |-> host_rxd_o == per_rxd_i)
      else $error("peripheral serial not forwarded");
   a_led2_steady: assert property ((boot_done_i && !fault_i) [*3] |-> led2_o)
      else $error("status led two not steady");
   a_led1_link: assert property ((link_up_i && !net_act_i) [*3] |-> led1_o)
      else $error("status led one not steady");
endmodule // csio_top_asserts
bind csio_top csio_top_asserts csio_top_asserts_i (.*);
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, re;
   logic        link_up_i = 1'h1, net_act_i = 1'h0, boot_done_i = 1'h1, fault_i = 1'h0;
   logic        ack_o, err_o, irq_o, host_txd_i, host_rxd_o, per_rxd_i, per_txd_o;
   logic        led1_o, led2_o;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'h1967ab50;
   logic [1:0]  sync_in_i, sync_out_o, lvl = 2'h0, prv = 2'h0;
   int          error_cnt = 0, checks_done = 0, cyc_n = 0, rs[2], w[2];
   int          m, s, d, e, l, tf, idl;
   always #12.5 clk_i = ~clk_i;
   csio_top csio_top_i (.*);
   csio_partner csio_partner_i (.clk_i, .rst_i, .lvl_i(lvl), .sync_o(sync_in_i),
      .txd_o(host_txd_i), .rxd_o(per_rxd_i));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int eexp(int x);
      return (x < 10) ? 10 : x;
   endfunction
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= wr;
      adr_i <= a;
      dat_i <= v;
      sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'h1 && err_o !== 1'h1);
      rd = dat_o;
      re = err_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // pulse start and width of both outputs, timeout
   always @(posedge clk_i) begin
      cyc_n++;
      prv <= sync_out_o;
      for (int b = 0; b < 2; b++) begin
         if (sync_out_o[b] && !prv[b]) rs[b] = int'($time);
         if (!sync_out_o[b] && prv[b]) w[b] = int'($time) - rs[b];
      end
      if (cyc_n > 40000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      bus(1'h0, 8'h00, 32'h0);
      chk("trig cfg", 32'h7, rd & 32'h7);
      bus(1'h0, 8'h08, 32'h0);
      chk("expo time", 32'ha, rd);
      bus(1'h0, 8'h28, 32'h0);
      chk("readout", 32'h3e8, rd);
      bus(1'h0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, re);
      bus(1'h1, 8'h0c, 32'h266);
      for (int b = 0; b < 2; b++) begin
         bus(1'h1, 8'h14, b);
         repeat (4) @(posedge clk_i);
         chk("sw bit", {~b[0], b[0]}, sync_out_o);
      end
      bus(1'h1, 8'h0c, 32'h22);
      for (int k = 0; k < 4; k++) begin
         bus(1'h1, 8'h00, {k[0], 4'h7});
         lvl[k[0]] <= k[1];
         repeat (8) @(posedge clk_i);
         chk("relay", k[1], sync_out_o[0]);
      end
      for (int k = 0; k < 10; k++) begin
         m = k % 5;
         s = xs() & 1;
         d = (k == 0) ? 0 : xs() % 4;
         e = (k == 9) ? 3 : 10 + xs() % 4;
         l = 4 + xs() % 16;
         idl = (m == 1 || m == 4);
         bus(1'h1, 8'h00, 32'h7);
         lvl <= {2{idl[0]}};
         bus(1'h1, 8'h04, d);
         bus(1'h1, 8'h08, e);
         bus(1'h1, 8'h28, 32'h1);
         bus(1'h1, 8'h10, l);
         bus(1'h1, 8'h0c, k[0] ? 32'h40 : 32'h50);
         bus(1'h1, 8'h24, k[0]);
         bus(1'h1, 8'h00, {s[0], 1'h0, m[2:0]});
         lvl[s] <= ~idl[0];
         tf = int'($time);
         repeat (10) @(posedge clk_i);
         lvl[s] <= idl[0];
         repeat ((d + eexp(e) + 1) * 40 + 80) @(posedge clk_i);
         chk("delay", 1, rs[0] - tf >= d * 1000 && rs[0] - tf <= d * 1000 + 300);
         chk("expo", 1, w[0] >= eexp(e) * 1000 - 50 && w[0] <= eexp(e) * 1000 + 50);
         if (k[0]) chk("imaging", 1, w[1] >= (eexp(e) + 1) * 1000 - 75
            && w[1] <= (eexp(e) + 1) * 1000 + 75);
         else chk("strobe", l * 25, w[1]);
         bus(1'h0, 8'h18, 32'h0);
         chk("ready", 32'h1, rd[0]);
         bus(1'h0, 8'h1c, 32'h0);
         chk("irq stat", 32'hd, rd & 32'hf);
         chk("irq", k[0], irq_o);
         bus(1'h1, 8'h20, 32'hf);
         chk("irq clear", 32'h0, irq_o);
      end
      fault_i <= 1'h1;
      bus(1'h1, 8'h00, 32'h107);
      bus(1'h0, 8'h18, 32'h0);
      chk("busy", 32'h0, rd[0]);
      chk("fault status", 32'h1, rd[3]);
      bus(1'h0, 8'h1c, 32'h0);
      chk("sw trigger", 32'h3, rd & 32'h3);
      fault_i <= 1'h0;
      finish_test();
   end
endmodule // tb_top
`default_nettype wire

/* hw/csio_map.vh */
`ifndef CSIO_MAP_VH
`define CSIO_MAP_VH
// register word offsets (byte addresses)
`define CSIO_REG_TRIG_CFG   8'h00
`define CSIO_REG_TRIG_DLY   8'h04
`define CSIO_REG_EXPO_TIME  8'h08
`define CSIO_REG_OUT_CFG    8'h0c
`define CSIO_REG_STROBE     8'h10
`define CSIO_REG_MISC       8'h14
`define CSIO_REG_STATUS     8'h18
`define CSIO_REG_IRQ_STAT   8'h1c
`define CSIO_REG_IRQ_CLR    8'h20
`define CSIO_REG_IRQ_EN     8'h24
`define CSIO_REG_READOUT    8'h28
// trigger event modes
`define CSIO_TRG_RISE       3'h0
`define CSIO_TRG_FALL       3'h1
`define CSIO_TRG_ANY        3'h2
`define CSIO_TRG_HIGH       3'h3
`define CSIO_TRG_LOW        3'h4
`define CSIO_TRG_OFF        3'h7
// output sources
`define CSIO_SRC_EXPO       3'h0
`define CSIO_SRC_READY      3'h1
`define CSIO_SRC_RELAY      3'h2
`define CSIO_SRC_READOUT    3'h3
`define CSIO_SRC_IMAGING    3'h4
`define CSIO_SRC_STROBE     3'h5
`define CSIO_SRC_SWBIT      3'h6
// timing
`define CSIO_CLK_MHZ        40
`define CSIO_US_CYCLES      6'd40
`define CSIO_MAX_US         26'd60000000
`define CSIO_MIN_EXPO_US    26'd10
`define CSIO_SEC_CYCLES     26'd40000000
`define CSIO_FLASH_CYCLES   26'd4000000
`define CSIO_ACT_CYCLES     26'd2000000
// reset values
`define CSIO_RST_EXPO       26'd10
`define CSIO_RST_READOUT    26'd1000
`endif

/* hw/csio_top.v */
// How it works
// [RULE_01] trigger fires on rising, falling, either edge or input level
// [RULE_02] capture starts only after programmed delay from the trigger event
// [RULE_03] either sync input can be chosen as trigger source
// [RULE_04] both sync outputs are output-only, each with a configured source
// [RULE_05] exposure source high exactly while sensor integrates
// [RULE_06] ready source high whenever a new trigger would be accepted
// [RULE_07] relay source copies the incoming trigger input
// [RULE_08] readout source high while sensor data is read out
// [RULE_09] imaging source is exposure OR readout
// [RULE_10] strobe source is programmable pulse started by a selected source
// [RULE_11] software bit source drives a level set by software
// [RULE_12] each source can be inverted before the pin
// [RULE_13] serial lines forwarded between network host and peripheral
// [RULE_14] led two: steady normal, one flash per second boot, three on fault
// [RULE_15] trigger delay 0 to 60 s in 1 us steps
// [RULE_16] five trigger events: rise, fall, any, level high, level low
// [RULE_17] exposure 10 us to 60 s in 1 us steps
// [RULE_18] led one steady on link, blinking with activity
// [RULE_19] each output has its own source and polarity
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`include "csio_map.vh"
`default_nettype none
module csio_top (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output wire        ack_o,
   output wire        err_o,
   output wire        irq_o,
   // sync pins
   input  wire [1:0]  sync_in_i,
   output reg  [1:0]  sync_out_o,
   // serial passthrough
   input  wire        host_txd_i,
   output reg         host_rxd_o,
   input  wire        per_rxd_i,
   output reg         per_txd_o,
   // network status and leds
   input  wire        link_up_i,
   input  wire        net_act_i,
   input  wire        boot_done_i,
   input  wire        fault_i,
   output reg         led1_o,
   output reg         led2_o
);
////////////////////////////////////////////////////////////////////////////////
// wishbone and registers
reg        ack;
reg  [2:0] trig_mode;
reg        trig_sel;
reg        sw_trig;
reg [25:0] trig_dly;
reg [25:0] expo_time;
reg [25:0] rd_time;
reg  [2:0] src_sel0;
reg  [2:0] src_sel1;
reg  [1:0] invert;
reg  [2:0] strobe_src;
reg [25:0] strobe_len;
reg        software_output_bit;
reg  [3:0] irq_stat;
reg  [3:0] irq_en;
wire       req = cyc_i & stb_i & ~ack;
wire       wr  = req & we_i & (&sel_i);
reg        hit;
wire [3:0] ev;
reg  [1:0] st;
assign ack_o = ack & hit;
assign err_o = ack & ~hit;
assign irq_o = |(irq_stat & irq_en);
always @* begin
   hit = 1'b1;
   if (adr_i == `CSIO_REG_TRIG_CFG) begin
      dat_o = {27'h0, trig_sel, 1'b0, trig_mode};
   end else if (adr_i == `CSIO_REG_TRIG_DLY) begin
      dat_o = {6'h0, trig_dly};
   end else if (adr_i == `CSIO_REG_EXPO_TIME) begin
      dat_o = {6'h0, expo_time};
   end else if (adr_i == `CSIO_REG_OUT_CFG) begin
      dat_o = {22'h0, invert, 1'b0, src_sel1, 1'b0, src_sel0};
   end else if (adr_i == `CSIO_REG_STROBE) begin
      dat_o = {3'h0, strobe_src, strobe_len};
   end else if (adr_i == `CSIO_REG_MISC) begin
      dat_o = {31'h0, software_output_bit};
   end else if (adr_i == `CSIO_REG_STATUS) begin
      dat_o = {28'h0, fault_i, boot_done_i, link_up_i, st == 2'd0};
   end else if (adr_i == `CSIO_REG_IRQ_STAT) begin
      dat_o = {28'h0, irq_stat};
   end else if (adr_i == `CSIO_REG_IRQ_CLR) begin
      dat_o = 32'h0;
   end else if (adr_i == `CSIO_REG_IRQ_EN) begin
      dat_o = {28'h0, irq_en};
   end else if (adr_i == `CSIO_REG_READOUT) begin
      dat_o = {6'h0, rd_time};
   end else begin
      dat_o = 32'h0;
      hit = 1'b0;
   end
end
always @(posedge clk_i) begin
   if (rst_i) begin
      ack <= 1'b0;
      trig_mode <= `CSIO_TRG_OFF;
      trig_sel <= 1'b0;
      trig_dly <= 26'h0;
      expo_time <= `CSIO_RST_EXPO;
      rd_time <= `CSIO_RST_READOUT;
      src_sel0 <= `CSIO_SRC_EXPO;
      src_sel1 <= `CSIO_SRC_READY;
      invert <= 2'h0;
      strobe_src <= `CSIO_SRC_EXPO;
      strobe_len <= 26'h1;
      software_output_bit <= 1'b0;
      irq_en <= 4'h0;
      sw_trig <= 1'b0;
   end else begin
      ack <= req;
      sw_trig <= 1'b0;
      if (wr && adr_i == `CSIO_REG_TRIG_CFG) begin
         trig_mode <= dat_i[2:0]; // RULE_16
         trig_sel <= dat_i[4]; // RULE_03
         sw_trig <= dat_i[8];
      end else if (wr && adr_i == `CSIO_REG_TRIG_DLY) begin
         trig_dly <= (dat_i[25:0] > `CSIO_MAX_US) ? `CSIO_MAX_US : dat_i[25:0]; // RULE_15
      end else if (wr && adr_i == `CSIO_REG_EXPO_TIME) begin
         if (dat_i[25:0] < `CSIO_MIN_EXPO_US) begin
            expo_time <= `CSIO_MIN_EXPO_US; // RULE_17
         end else if (dat_i[25:0] > `CSIO_MAX_US) begin
            expo_time <= `CSIO_MAX_US; // RULE_17
         end else begin
            expo_time <= dat_i[25:0];
         end
      end else if (wr && adr_i == `CSIO_REG_OUT_CFG) begin
         src_sel0 <= dat_i[2:0]; // RULE_19
         src_sel1 <= dat_i[6:4]; // RULE_19
         invert <= dat_i[9:8];
      end else if (wr && adr_i == `CSIO_REG_STROBE) begin
         strobe_len <= dat_i[25:0];
         strobe_src <= dat_i[28:26];
      end else if (wr && adr_i == `CSIO_REG_MISC) begin
         software_output_bit <= dat_i[0]; // RULE_11
      end else if (wr && adr_i == `CSIO_REG_IRQ_EN) begin
         irq_en <= dat_i[3:0];
      end else if (wr && adr_i == `CSIO_REG_READOUT) begin
         rd_time <= dat_i[25:0];
      end
   end
end
// sticky events: set wins over clear
always @(posedge clk_i) begin
   if (rst_i) begin
      irq_stat <= 4'h0;
   end else if (wr && adr_i == `CSIO_REG_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~dat_i[3:0]) | ev;
   end else begin
      irq_stat <= irq_stat | ev;
   end
end
////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [2:0] s0;
reg [2:0] s1;
reg [2:0] sr;
reg [2:0] sh;
reg [1:0] sync_q;
reg       per_q;
reg       host_q;
always @(posedge clk_i) begin
   if (rst_i) begin
      s0 <= 3'h0;
      s1 <= 3'h0;
      sr <= 3'h7;
      sh <= 3'h7;
      sync_q <= 2'h0;
      per_q <= 1'b1;
      host_q <= 1'b1;
   end else begin
      s0 <= {s0[1:0], sync_in_i[0]};
      s1 <= {s1[1:0], sync_in_i[1]};
      sr <= {sr[1:0], per_rxd_i};
      sh <= {sh[1:0], host_txd_i};
      if (s0[1] == s0[2]) sync_q[0] <= s0[2];
      if (s1[1] == s1[2]) sync_q[1] <= s1[2];
      if (sr[1] == sr[2]) per_q <= sr[2];
      if (sh[1] == sh[2]) host_q <= sh[2];
   end
end
////////////////////////////////////////////////////////////////////////////////
// trigger qualifier and capture sequencer
localparam ST_IDLE = 2'd0;
localparam ST_WAIT = 2'd1;
localparam ST_EXPO = 2'd2;
localparam ST_READ = 2'd3;
reg        trg_prev;
reg  [5:0] us_cnt;
reg [25:0] cnt;
wire       trg_lvl = trig_sel ? sync_q[1] : sync_q[0]; // RULE_03
reg        qual;
always @* begin
   case (trig_mode) // RULE_01
      `CSIO_TRG_RISE: qual = trg_lvl & ~trg_prev;
      `CSIO_TRG_FALL: qual = ~trg_lvl & trg_prev;
      `CSIO_TRG_ANY:  qual = trg_lvl ^ trg_prev;
      `CSIO_TRG_HIGH: qual = trg_lvl;
      `CSIO_TRG_LOW:  qual = ~trg_lvl;
      default:        qual = 1'b0;
   endcase
end
wire fire = (st == ST_IDLE) & (qual | sw_trig);
wire us_tick = (us_cnt == `CSIO_US_CYCLES - 6'd1);
always @(posedge clk_i) begin
   if (rst_i) begin
      st <= ST_IDLE;
      trg_prev <= 1'b0;
      us_cnt <= 6'h0;
      cnt <= 26'h0;
   end else begin
      trg_prev <= trg_lvl;
      us_cnt <= (us_tick || fire) ? 6'h0 : us_cnt + 6'd1;
      case (st)
         ST_IDLE: begin
            cnt <= 26'h0;
            if (fire) st <= (trig_dly == 26'h0) ? ST_EXPO : ST_WAIT; // RULE_02
         end
         ST_WAIT: begin
            if (us_tick) begin
               if (cnt + 26'd1 >= trig_dly) begin // RULE_02
                  st <= ST_EXPO;
                  cnt <= 26'h0;
               end else begin
                  cnt <= cnt + 26'd1;
               end
            end
         end
         ST_EXPO: begin
            if (us_tick) begin
               if (cnt + 26'd1 >= expo_time) begin // RULE_17
                  st <= ST_READ;
                  cnt <= 26'h0;
               end else begin
                  cnt <= cnt + 26'd1;
               end
            end
         end
         default: begin
            if (us_tick) begin
               if (cnt + 26'd1 >= rd_time) begin
                  st <= ST_IDLE;
                  cnt <= 26'h0;
               end else begin
                  cnt <= cnt + 26'd1;
               end
            end
         end
      endcase
   end
end
////////////////////////////////////////////////////////////////////////////////
// output sources, strobe and pins
reg  [6:0] srcs;
reg  [6:0] srcs_prev;
reg [25:0] strb_cnt;
always @* begin
   srcs[`CSIO_SRC_EXPO]    = (st == ST_EXPO); // RULE_05
   srcs[`CSIO_SRC_READY]   = (st == ST_IDLE); // RULE_06
   srcs[`CSIO_SRC_RELAY]   = trg_lvl; // RULE_07
   srcs[`CSIO_SRC_READOUT] = (st == ST_READ); // RULE_08
   srcs[`CSIO_SRC_IMAGING] = (st == ST_EXPO) | (st == ST_READ); // RULE_09
   srcs[`CSIO_SRC_STROBE]  = (strb_cnt != 26'h0); // RULE_10
   srcs[`CSIO_SRC_SWBIT]   = software_output_bit; // RULE_11
end
wire strb_start = srcs[strobe_src] & ~srcs_prev[strobe_src] & (strobe_src != `CSIO_SRC_STROBE);
assign ev = {srcs[`CSIO_SRC_READOUT] & ~srcs_prev[`CSIO_SRC_READOUT],
             srcs[`CSIO_SRC_EXPO] & ~srcs_prev[`CSIO_SRC_EXPO], fault_i, fire};
genvar gi;
generate
   for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
      wire [2:0] sel = (gi == 0) ? src_sel0 : src_sel1;
      always @(posedge clk_i) begin
         if (rst_i) begin
            sync_out_o[gi] <= 1'b0;
         end else begin
            sync_out_o[gi] <= (sel > `CSIO_SRC_SWBIT ? 1'b0 : srcs[sel]) ^ invert[gi]; // RULE_04 RULE_12
         end
      end
   end
endgenerate
always @(posedge clk_i) begin
   if (rst_i) begin
      srcs_prev <= 7'h0;
      strb_cnt <= 26'h0;
      host_rxd_o <= 1'b1;
      per_txd_o <= 1'b1;
   end else begin
      srcs_prev <= srcs;
      if (strb_start) begin
         strb_cnt <= strobe_len; // RULE_10
      end else if (strb_cnt != 26'h0) begin
         strb_cnt <= strb_cnt - 26'd1;
      end
      per_txd_o <= host_q; // RULE_13
      host_rxd_o <= per_q; // RULE_13
   end
end
////////////////////////////////////////////////////////////////////////////////
// status leds
reg [25:0] sec_cnt;
reg [25:0] act_cnt;
always @(posedge clk_i) begin
   if (rst_i) begin
      sec_cnt <= 26'h0;
      act_cnt <= 26'h0;
      led1_o <= 1'b0;
      led2_o <= 1'b0;
   end else begin
      sec_cnt <= (sec_cnt == `CSIO_SEC_CYCLES - 26'd1) ? 26'h0 : sec_cnt + 26'd1;
      act_cnt <= (act_cnt == `CSIO_ACT_CYCLES * 2 - 26'd1) ? 26'h0 : act_cnt + 26'd1;
      led1_o <= link_up_i & ~(net_act_i & (act_cnt >= `CSIO_ACT_CYCLES)); // RULE_18
      if (fault_i) begin
         led2_o <= (sec_cnt < `CSIO_FLASH_CYCLES * 6) &
                   ((sec_cnt / `CSIO_FLASH_CYCLES) % 2 == 26'd0); // RULE_14
      end else if (!boot_done_i) begin
         led2_o <= (sec_cnt < `CSIO_FLASH_CYCLES * 2); // RULE_14
      end else begin
         led2_o <= 1'b1; // RULE_14
      end
   end
end
endmodule // csio_top
`default_nettype wire
